// [hdl/tchrp_pkg.sv]
package tchrp_pkg;
   localparam logic [1:0] ADDR_IRQ_CTRL_STATUS = 2'h0;
   localparam logic [1:0] ADDR_TIMECODE_STATUS = 2'h1;
   localparam logic [1:0] ADDR_INDIRECT_POINTER = 2'h2;
   localparam logic [1:0] ADDR_INDIRECT_DATA = 2'h3;
   // interrupt control/status layout: flags in low nibble, enables high
   localparam int BIT_RX_FRAME_FLAG = 0;
   localparam int BIT_TX_FRAME_FLAG = 1;
   localparam int BIT_VIDEO_LINE_FLAG = 2;
   localparam int BIT_TIMER_FLAG = 3;
   localparam int BIT_IRQ_EN_LSB = 4;
   // timecode status layout
   localparam int BIT_AB_PIN_STATE = 0;
   localparam int BIT_SYNC_PIN_STATE = 1;
   localparam int BIT_CODE_LOCK = 2;
   localparam int BIT_CODE_REVERSE = 3;
   localparam int BIT_GENLOCK_LOCKED = 4;
   localparam int BIT_FIELD_EVEN = 6;
   localparam int BIT_COLOUR_FRAME = 7;
   // pointer layout
   localparam int BIT_POINTER_STEP = 7;
   localparam int INDIRECT_ADDR_W = 6;
   localparam int INDIRECT_DEPTH = 64;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [5:0] RESET_INDIRECT_ADDR = 6'h00;
   // pin synchronisers start at the pins' idle levels: selects and strobes high
   localparam logic [11:0] RESET_PIN_SYNC = 12'h660;
endpackage

// [hdl/tchrp_register_port.sv]
`timescale 1ns/1ps
`default_nettype none
module tchrp_register_port (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_master_reset,
   input wire logic i_timecode_port_select_n,
   input wire logic i_serial_port_select_n,
   input wire logic [1:0] i_addr,
   input wire logic i_host_read_strobe_n,
   input wire logic i_host_write_strobe_n,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe,
   output logic o_serial_port_access,
   output logic o_host_irq,
   input wire logic i_rx_frame_done,
   input wire logic i_tx_buffer_load,
   input wire logic i_tx_enable_bit,
   input wire logic i_video_line_passed,
   input wire logic i_timer_expired,
   input wire logic i_code_lock,
   input wire logic i_code_reverse,
   input wire logic i_genlock_locked,
   input wire logic i_field_even,
   input wire logic i_colour_frame,
   input wire logic i_ab_pin,
   input wire logic i_sync_pin,
   output logic [5:0] o_ind_addr,
   output logic [7:0] o_ind_wdata,
   output logic o_ind_write,
   output logic o_ind_read,
   input wire logic [7:0] i_ind_rdata
);
   import tchrp_pkg::*;

   // two-flop synchronisers on every host pin and async level
   localparam int NSYNC = 12;
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;
   logic [7:0] wdata1_ff;
   logic [7:0] wdata2_ff;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_ff <= RESET_PIN_SYNC; // avoids a false access right after reset
         sync2_ff <= RESET_PIN_SYNC;
         wdata1_ff <= RESET_BYTE;
         wdata2_ff <= RESET_BYTE;
      end else begin
         sync1_ff <= {i_master_reset, i_timecode_port_select_n, i_serial_port_select_n, i_addr,
                      i_host_read_strobe_n, i_host_write_strobe_n, i_ab_pin, i_sync_pin,
                      i_colour_frame, i_field_even, i_genlock_locked};
         sync2_ff <= sync1_ff;
         wdata1_ff <= i_data;
         wdata2_ff <= wdata1_ff;
      end
   end

   logic mrst;
   logic cs_n;
   logic ucs_n;
   logic [1:0] addr;
   logic rd_n;
   logic wr_n;
   logic ab_s;
   logic sync_s;
   logic cf_s;
   logic fe_s;
   logic gl_s;
   assign {mrst, cs_n, ucs_n, addr, rd_n, wr_n, ab_s, sync_s, cf_s, fe_s, gl_s} = sync2_ff;

   // access is select low together with a strobe low
   logic rd_act;
   logic wr_act;
   logic rd_prev_ff;
   logic wr_prev_ff;
   assign rd_act = !cs_n && !rd_n;
   assign wr_act = !cs_n && !wr_n;
   logic rd_start;
   logic rd_end;
   logic wr_end;
   assign rd_start = rd_act && !rd_prev_ff;
   assign rd_end = !rd_act && rd_prev_ff;
   assign wr_end = !wr_act && wr_prev_ff;

   // register address latched at strobe start, held through the cycle
   logic [1:0] acc_addr_ff;
   logic [7:0] wlatch_ff;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_prev_ff <= 1'b0;
         wr_prev_ff <= 1'b0;
         acc_addr_ff <= 2'h0;
         wlatch_ff <= RESET_BYTE;
      end else begin
         rd_prev_ff <= rd_act;
         wr_prev_ff <= wr_act;
         if ((rd_act && !rd_prev_ff) || (wr_act && !wr_prev_ff)) begin
            acc_addr_ff <= addr;
         end
         if (wr_act) begin
            wlatch_ff <= wdata2_ff; // data sampled until strobe rises
         end
      end
   end

   // serial port select only flagged out; its registers live elsewhere
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_serial_port_access <= 1'b0;
      end else begin
         o_serial_port_access <= !ucs_n && (!rd_n || !wr_n);
      end
   end

   // interrupt flags; a new event outranks the clearing read
   logic [3:0] flags_ff;
   logic [3:0] irq_en_ff;
   logic [3:0] events;
   logic clr_flags;
   assign events[BIT_RX_FRAME_FLAG] = i_rx_frame_done;
   assign events[BIT_TX_FRAME_FLAG] = i_tx_buffer_load && i_tx_enable_bit;
   assign events[BIT_VIDEO_LINE_FLAG] = i_video_line_passed;
   assign events[BIT_TIMER_FLAG] = i_timer_expired;
   // clear at the end of the read so the host sees the flags it clears
   assign clr_flags = rd_end && acc_addr_ff == ADDR_IRQ_CTRL_STATUS;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags_ff <= 4'h0;
      end else if (mrst) begin
         flags_ff <= 4'h0;
      end else begin
         flags_ff <= (clr_flags ? 4'h0 : flags_ff) | events;
      end
   end

   // enables are host written and survive the clearing read
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_en_ff <= 4'h0;
      end else if (mrst) begin
         irq_en_ff <= 4'h0;
      end else if (wr_end && acc_addr_ff == ADDR_IRQ_CTRL_STATUS) begin
         irq_en_ff <= wlatch_ff[BIT_IRQ_EN_LSB +: 4];
      end
   end

   // active-high request line
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_host_irq <= 1'b0;
      end else begin
         o_host_irq <= |(flags_ff & irq_en_ff);
      end
   end

   // pointer: step bit plus six-bit indirect address
   logic step_ff;
   logic [INDIRECT_ADDR_W-1:0] ind_addr_ff;
   logic win_end;
   assign win_end = (rd_end || wr_end) && acc_addr_ff == ADDR_INDIRECT_DATA;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         step_ff <= 1'b0;
         ind_addr_ff <= RESET_INDIRECT_ADDR;
      end else if (mrst) begin
         step_ff <= 1'b0;
         ind_addr_ff <= RESET_INDIRECT_ADDR;
      end else if (wr_end && acc_addr_ff == ADDR_INDIRECT_POINTER) begin
         step_ff <= wlatch_ff[BIT_POINTER_STEP];
         ind_addr_ff <= wlatch_ff[INDIRECT_ADDR_W-1:0];
      end else if (win_end && step_ff) begin
         ind_addr_ff <= ind_addr_ff + 6'h01; // wraps at 64
      end
   end

   // window strobes toward the 64 internal registers
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ind_addr <= RESET_INDIRECT_ADDR;
         o_ind_wdata <= RESET_BYTE;
         o_ind_write <= 1'b0;
         o_ind_read <= 1'b0;
      end else begin
         o_ind_addr <= ind_addr_ff;
         o_ind_wdata <= wlatch_ff;
         o_ind_write <= wr_end && acc_addr_ff == ADDR_INDIRECT_DATA;
         o_ind_read <= rd_start && addr == ADDR_INDIRECT_DATA;
      end
   end

   // status byte; reverse bit forced low when unlocked
   logic [7:0] status;
   always_comb begin
      status = RESET_BYTE;
      status[BIT_AB_PIN_STATE] = ab_s;
      status[BIT_SYNC_PIN_STATE] = sync_s;
      status[BIT_CODE_LOCK] = i_code_lock;
      status[BIT_CODE_REVERSE] = i_code_lock && i_code_reverse;
      status[BIT_GENLOCK_LOCKED] = gl_s;
      status[BIT_FIELD_EVEN] = fe_s;
      status[BIT_COLOUR_FRAME] = cf_s;
   end

   function automatic logic [7:0] read_mux(input logic [1:0] a, input logic [7:0] st,
                                           input logic [7:0] ir, input logic [7:0] ptr,
                                           input logic [7:0] ind);
      unique case (a)
         ADDR_IRQ_CTRL_STATUS: read_mux = ir;
         ADDR_TIMECODE_STATUS: read_mux = st;
         ADDR_INDIRECT_POINTER: read_mux = ptr;
         ADDR_INDIRECT_DATA: read_mux = ind;
      endcase
   endfunction

   // read data; status stays live while strobe low, writes ignored there
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_data <= RESET_BYTE;
         o_data_oe <= 1'b0;
      end else begin
         o_data_oe <= rd_act;
         if (rd_act) begin
            o_data <= read_mux(rd_start ? addr : acc_addr_ff, status, {irq_en_ff, flags_ff},
                               {step_ff, 1'b0, ind_addr_ff}, i_ind_rdata);
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/tchrp_ind_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tchrp_ind_model (
   input wire logic i_clk_sys,
   input wire logic [5:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_write,
   input wire logic i_read,
   output logic [7:0] o_rdata
);
   logic [7:0] mem_ff [64];
   logic [7:0] last_ff;
   logic [3:0] hold_ff;
   // data stands through the strobe, then inverts so a late sample cannot pass
   always_ff @(posedge i_clk_sys) begin
      if (i_write) mem_ff[i_addr] <= i_wdata;
      if (i_read) last_ff <= mem_ff[i_addr];
      hold_ff <= i_read ? 4'hf : hold_ff - {3'h0, hold_ff != 4'h0};
   end
   assign o_rdata = (hold_ff != 4'h0) ? last_ff : ~last_ff;
endmodule
`default_nettype wire

// [testbench/tchrp_register_port_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module tchrp_register_port_monitor (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_master_reset,
   input wire logic i_timecode_port_select_n,
   input wire logic i_serial_port_select_n,
   input wire logic [1:0] i_addr,
   input wire logic i_host_read_strobe_n,
   input wire logic o_data_oe,
   input wire logic o_serial_port_access,
   input wire logic o_host_irq,
   input wire logic [5:0] o_ind_addr,
   input wire logic o_ind_write,
   input wire logic o_ind_read
);
   // windows allow for the two sync flops on every pin
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   mr_clear_a: assert property (i_master_reset [*6] |-> !o_host_irq && o_ind_addr == 6'h00)
      else $error("master reset left state");
   oe_idle_a: assert property ((i_host_read_strobe_n | i_timecode_port_select_n) [*6] |-> !o_data_oe)
      else $error("bus driven without read");
   ser_on_a: assert property ((!i_serial_port_select_n && !i_host_read_strobe_n) [*5] |->
      o_serial_port_access) else $error("serial access missed");
   ser_off_a: assert property (i_serial_port_select_n [*5] |-> !o_serial_port_access)
      else $error("serial access stray");
   win_read_a: assert property (o_ind_read |-> i_addr == 2'h3 &&
      !i_timecode_port_select_n && !i_host_read_strobe_n) else $error("indirect read outside window");
   ptr_step_a: assert property (o_ind_write |-> ##2 6'(o_ind_addr - $past(o_ind_addr, 2)) <= 6'h01)
      else $error("pointer moved by more than one");
   rd_clear_a: assert property ($rose(i_host_read_strobe_n) &&
      $past(!i_timecode_port_select_n && i_addr == 2'h0) |-> ##6 !o_host_irq) else $error("irq kept after read");
   wr_pulse_a: assert property (o_ind_write |=> !o_ind_write && !o_ind_read)
      else $error("write pulse too long");
   cover property (o_ind_write);
   cover property (o_ind_read);
   cover property (o_host_irq ##1 !o_host_irq);
endmodule
bind tchrp_register_port tchrp_register_port_monitor mon (.*);
`default_nettype wire

// [testbench/tchrp_register_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tchrp_register_port_tb;
   logic clk = 0, rst_n = 0, mr = 0, tc_n = 1, ser_n = 1, rd_n = 1, wr_n = 1, oe, sacc, irq, iw, ir;
   logic [1:0] a = 2'h0;
   logic [7:0] d = 8'h00, st = 8'h00, q, dq, iwd, ird;
   logic [3:0] evp = 4'h0;
   logic [5:0] ia;
   logic txen = 1'h1;
   int fails = 0, checks = 0;
   always #2.5 clk = ~clk;
   tchrp_register_port uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_master_reset(mr), .i_data(d),
      .i_timecode_port_select_n(tc_n), .i_serial_port_select_n(ser_n), .i_addr(a), .o_data(dq),
      .i_host_read_strobe_n(rd_n), .i_host_write_strobe_n(wr_n), .o_data_oe(oe), .o_host_irq(irq),
      .o_serial_port_access(sacc), .i_rx_frame_done(evp[0]), .i_tx_buffer_load(evp[1]),
      .i_video_line_passed(evp[2]), .i_timer_expired(evp[3]), .i_tx_enable_bit(txen),
      .i_ab_pin(st[0]), .i_sync_pin(st[1]), .i_code_lock(st[2]), .i_code_reverse(st[3]),
      .i_genlock_locked(st[4]), .i_field_even(st[6]), .i_colour_frame(st[7]), .o_ind_addr(ia),
      .o_ind_wdata(iwd), .o_ind_write(iw), .o_ind_read(ir), .i_ind_rdata(ird));
   tchrp_ind_model far (.i_clk_sys(clk), .i_addr(ia), .i_wdata(iwd), .i_write(iw), .i_read(ir), .o_rdata(ird));
   task automatic check(input string n, input logic [7:0] g, e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // strobe low six clocks covers the pin sync lag; select lifts a clock later
   task automatic io(input logic [1:0] ad, input logic w, input logic [7:0] v);
      {a, d, tc_n, rd_n, wr_n} = {ad, v, 1'h0, w, !w};
      repeat (6) @(negedge clk);
      q = dq;
      {rd_n, wr_n} = 2'h3;
      @(negedge clk);
      tc_n = 1'h1;
      repeat (6) @(negedge clk);
   endtask
   task automatic rd(input logic [1:0] ad, input logic [7:0] e, input string n);
      io(ad, 1'h0, 8'h00);
      check(n, q, e);
   endtask
   task automatic t_ind;
      io(2'h2, 1'h1, 8'hBF);
      io(2'h3, 1'h1, 8'h5A);
      rd(2'h2, 8'h80, "ptr wrap");
      io(2'h2, 1'h1, 8'h7F);
      rd(2'h3, 8'h5A, "window");
      rd(2'h2, 8'h3F, "ptr held");
   endtask
   // timer gets every enable but its own, so it must stay silent
   task automatic t_irq;
      logic [7:0] en;
      for (int i = 0; i < 4; i++) begin
         en = (i == 3) ? 8'h70 : 8'hF0;
         io(2'h0, 1'h1, en);
         evp[i] = 1'h1;
         @(negedge clk);
         evp = 4'h0;
         repeat (3) @(negedge clk);
         check("irq", {7'h00, irq}, {7'h00, i != 3});
         rd(2'h0, en | (8'h01 << i), "flags");
         rd(2'h0, en, "cleared");
         check("irq off", {7'h00, irq}, 8'h00);
      end
      // transmit event with transmit off must not raise its flag
      txen = 1'h0;
      evp[1] = 1'h1;
      @(negedge clk);
      evp = 4'h0;
      rd(2'h0, en, "tx gated");
      txen = 1'h1;
   endtask
   task automatic t_misc;
      st = 8'hFA;
      rd(2'h1, 8'hD2, "status");
      io(2'h1, 1'h1, 8'h00);
      st = 8'hDD;
      rd(2'h1, 8'hDD, "status ro");
      {ser_n, rd_n} = 2'h0;
      repeat (6) @(negedge clk);
      check("serial", {6'h00, sacc, oe}, 8'h02);
      {ser_n, rd_n, mr} = 3'h7;
      repeat (8) @(negedge clk);
      mr = 1'h0;
      repeat (4) @(negedge clk);
      rd(2'h2, 8'h00, "mr ptr");
      rd(2'h0, 8'h00, "mr enables");
   endtask
   task automatic final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'h1;
      repeat (4) @(negedge clk);
      t_ind;
      t_irq;
      t_misc;
      final_report;
   end
   // hang guard, well past the 2 us the sequence takes
   initial begin
      #20000;
      fails++;
      final_report;
   end
endmodule
`default_nettype wire
